// ### logic/ccsr_core_state.sv
`timescale 1ns/1ps
// Summary of operation
// - status flags update after every alu operation for later conditional tests
// - status is never saved on interrupt entry nor restored on return
// - bit 7 is the global interrupt gate; clear blocks all interrupts
// - gate clears on interrupt entry, sets on interrupt exit, direct set/clear too
// - bit 6 is a copy bit: store-bit fills it, load-bit copies it out
// - bit 5 flags low-nibble carry for operations that define it
// - bit 4 equals negative xor overflow, except after status is written through its i/o address
// - bit 3 reports two's complement overflow
// - bit 2 flags negative result, bit 1 flags zero result
// - bit 0 reports carry from arithmetic or logic
// - file offers byte/byte, two-byte/byte, two-byte/pair, pair/pair port schemes
// - working registers also answer at data addresses 0 to 31
// - registers 26..31 form three 16-bit pointers, even byte low
// - pointers support displacement, post-increment, pre-decrement with write-back
// - stack grows down; byte push decrements by one, pop increments by one
// - call or interrupt entry decrements by two, interrupt return increments by two
// - stack pointer resets to 0x10ff
// - stack pointer is two i/o bytes; high byte upper three bits read zero
// - page bit selects program half for extended loads only
// - page select bits 7..1 always read zero
// - read two operands into the opnd_a/opnd_b registers, then compute and write back: two clock cycles
module ccsr_core_state (
  input wire logic clk_sys,
  input wire logic rstn,
  // alu side: result and per-flag update mask
  input wire logic [4:0] alu_src_a,
  input wire logic [4:0] alu_src_b,
  input wire logic [4:0] alu_dst,
  input wire logic alu_wr,
  input wire logic alu_wide,
  input wire logic [15:0] alu_result,
  input wire logic [7:0] alu_flags,
  input wire logic [7:0] alu_flag_mask,
  output logic [7:0] opnd_a,
  output logic [7:0] opnd_b,
  output logic [15:0] opnd_w,
  // bit copy
  input wire logic bit_store,
  input wire logic bit_load,
  input wire logic [2:0] bit_sel,
  // interrupt gate
  input wire logic irq_request,
  input wire logic irq_enter,
  input wire logic irq_exit,
  input wire logic gate_set,
  input wire logic gate_clear,
  output logic irq_take,
  // stack
  input wire ccsr_pkg::ccsr_sp_op_t sp_op,
  output logic [15:0] stack_ptr,
  // pointer addressing
  input wire ccsr_pkg::ccsr_ptr_mode_t ptr_mode,
  input wire logic [1:0] ptr_sel,
  input wire logic [5:0] ptr_disp,
  output logic [15:0] ptr_addr,
  // data space access to the file
  input wire logic [15:0] ds_addr,
  input wire logic ds_wr,
  input wire logic ds_rd,
  input wire logic [7:0] ds_wdata,
  output logic [7:0] ds_rdata,
  output logic ds_hit,
  // i/o register port
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // program memory page
  input wire logic ext_table_access,
  input wire logic [15:0] z_prog_addr,
  output logic [16:0] prog_addr
);
  import ccsr_pkg::*;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic [4:0] ptr_low(input logic [1:0] sel);
    unique case (sel)
      2'd0: ptr_low = PTR_X_LOW;
      2'd1: ptr_low = PTR_Y_LOW;
      default: ptr_low = PTR_Z_LOW;
    endcase
  endfunction : ptr_low

  function automatic logic in_file(input logic [15:0] a);
    in_file = (a <= RF_DATA_TOP);
  endfunction : in_file

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  ccsr_rf_if rf ();
  ccsr_regfile u_rf (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .rf(rf)
  );

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  ccsr_state_t st;
  ccsr_state_t next_st;
  logic [15:0] ptr_cur;
  logic [15:0] ptr_new;
  logic [15:0] eff_addr;
  logic [7:0] new_flags;
  logic [7:0] bit_mask;
  logic [7:0] io_val;
  logic ds_sel;

  // file port mux: pointer write-back, then data-space, then alu, then bit load
  always_comb begin
    ptr_cur = '0;
    rf.rd_a_idx = alu_src_a;
    rf.rd_b_idx = alu_src_b;
    rf.wr_idx = alu_dst;
    rf.wr_en = 1'b0;
    rf.wr_wide = 1'b0;
    rf.wr_data = alu_result;
    bit_mask = 8'h01 << bit_sel;
    ds_sel = in_file(ds_addr);
    if (ptr_mode != PTR_NONE) begin
      rf.rd_a_idx = ptr_low(ptr_sel);
    end
    ptr_cur = rf.rd_w;
    ptr_new = ptr_cur;
    eff_addr = ptr_cur;
    unique case (ptr_mode)
      PTR_DISP: eff_addr = ptr_cur + {10'h000, ptr_disp};
      PTR_POSTINC: ptr_new = ptr_cur + 16'h0001;
      PTR_PREDEC: begin
        ptr_new = ptr_cur - 16'h0001;
        eff_addr = ptr_new;
      end
      PTR_NONE: ;
    endcase
    if (ptr_mode == PTR_POSTINC || ptr_mode == PTR_PREDEC) begin
      rf.wr_idx = ptr_low(ptr_sel);
      rf.wr_en = 1'b1;
      rf.wr_wide = 1'b1;
      rf.wr_data = ptr_new;
    end else if (ds_wr && ds_sel) begin
      rf.wr_idx = ds_addr[4:0];
      rf.wr_en = 1'b1;
      rf.wr_data = {8'h00, ds_wdata};
    end else if (ds_rd && ds_sel) begin
      rf.rd_b_idx = ds_addr[4:0];
    end else if (alu_wr) begin
      rf.wr_en = 1'b1;
      rf.wr_wide = alu_wide;
    end else if (bit_load) begin
      rf.wr_en = 1'b1;
      rf.wr_data = {8'h00, st.status[FLAG_T] ? (rf.rd_a | bit_mask) : (rf.rd_a & ~bit_mask)};
    end
  end

  // flags: bits 5 and 3..0 update only where the instruction's mask is set; bit 4 follows n xor v
  always_comb begin
    new_flags = (st.status & ~alu_flag_mask) | (alu_flags & alu_flag_mask);
    // carry, zero, negative, overflow, half carry come from the alu result path
    new_flags[FLAG_S] = new_flags[FLAG_N] ^ new_flags[FLAG_V];
    new_flags[FLAG_T] = st.status[FLAG_T];
    new_flags[FLAG_I] = st.status[FLAG_I];
  end

  always_comb begin
    next_st = st;
    next_st.status = new_flags;
    if (bit_store) begin
      next_st.status[FLAG_T] = rf.rd_a[bit_sel];
    end
    // entry touches only the gate; other flags are the program's to save
    if (irq_enter || gate_clear) begin
      next_st.status[FLAG_I] = 1'b0;
    end else if (irq_exit || gate_set) begin
      next_st.status[FLAG_I] = 1'b1;
    end
    unique case (sp_op)
      SP_PUSH1: next_st.sp = st.sp - SP_STEP_BYTE;
      SP_POP1: next_st.sp = st.sp + SP_STEP_BYTE;
      SP_PUSH2: next_st.sp = st.sp - SP_STEP_ADDR;
      SP_HOLD: ;
    endcase
    if (irq_enter) begin
      next_st.sp = st.sp - SP_STEP_ADDR;
    end else if (irq_exit) begin
      next_st.sp = st.sp + SP_STEP_ADDR;
    end
    if (io_wr) begin
      unique case (io_addr)
        IO_STATUS: next_st.status = io_wdata;
        IO_SP_LOW: next_st.sp[7:0] = io_wdata;
        IO_SP_HIGH: next_st.sp[15:8] = io_wdata & SP_HIGH_MASK;
        IO_PAGE_SELECT: next_st.page = io_wdata & PAGE_MASK;
        default: ;
      endcase
    end
    next_st.sp[15:8] = next_st.sp[15:8] & SP_HIGH_MASK;
  end

  always_comb begin
    unique case (io_addr)
      IO_STATUS: io_val = st.status;
      IO_SP_LOW: io_val = st.sp[7:0];
      IO_SP_HIGH: io_val = st.sp[15:8];
      IO_PAGE_SELECT: io_val = st.page;
      default: io_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{status: STATUS_RESET, page: PAGE_RESET,
              sp: {SP_HIGH_RESET, SP_LOW_RESET}};
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  // the stack pointer is trusted as set; software keeps it above 0x0100
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      opnd_a <= 8'h00;
      opnd_b <= 8'h00;
      opnd_w <= 16'h0000;
      irq_take <= 1'b0;
      stack_ptr <= {SP_HIGH_RESET, SP_LOW_RESET};
      ptr_addr <= 16'h0000;
      ds_rdata <= 8'h00;
      ds_hit <= 1'b0;
      io_rdata <= 8'h00;
      prog_addr <= 17'h0_0000;
    end else begin
      opnd_a <= rf.rd_a;
      opnd_b <= rf.rd_b;
      opnd_w <= rf.rd_w;
      // a clear in the same cycle as the request still blocks it
      irq_take <= irq_request && st.status[FLAG_I] && !gate_clear;
      stack_ptr <= next_st.sp;
      ptr_addr <= eff_addr;
      ds_rdata <= (ds_rd && ds_sel) ? rf.rd_b : 8'h00;
      ds_hit <= (ds_rd || ds_wr) && ds_sel;
      io_rdata <= io_rd ? io_val : 8'h00;
      // plain table loads stay in the lower half regardless of the page bit
      prog_addr <= {ext_table_access & st.page[PAGE_BIT], z_prog_addr};
    end
  end
endmodule : ccsr_core_state

// ### logic/ccsr_pkg.sv
package ccsr_pkg;
  // ------------------------------------------------------------
  // i/o offsets
  // ------------------------------------------------------------
  localparam logic [5:0] IO_PAGE_SELECT = 6'h3B;
  localparam logic [5:0] IO_SP_LOW = 6'h3D;
  localparam logic [5:0] IO_SP_HIGH = 6'h3E;
  localparam logic [5:0] IO_STATUS = 6'h3F;
  // ------------------------------------------------------------
  // status bit positions
  // ------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam int PAGE_BIT = 0;
  // ------------------------------------------------------------
  // reset values and sizes
  // ------------------------------------------------------------
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] SP_LOW_RESET = 8'hFF;
  localparam logic [7:0] SP_HIGH_RESET = 8'h10;
  localparam logic [7:0] SP_HIGH_MASK = 8'h1F;
  localparam logic [7:0] PAGE_MASK = 8'h01;
  localparam logic [4:0] PTR_X_LOW = 5'h1A;
  localparam logic [4:0] PTR_Y_LOW = 5'h1C;
  localparam logic [4:0] PTR_Z_LOW = 5'h1E;
  localparam logic [15:0] RF_DATA_TOP = 16'h001F;
  localparam logic [15:0] SP_STEP_BYTE = 16'h0001;
  localparam logic [15:0] SP_STEP_ADDR = 16'h0002;

  typedef enum logic [1:0] {
    SP_HOLD,
    SP_PUSH1,
    SP_PUSH2,
    SP_POP1
  } ccsr_sp_op_t;

  typedef enum logic [1:0] {
    PTR_NONE,
    PTR_DISP,
    PTR_POSTINC,
    PTR_PREDEC
  } ccsr_ptr_mode_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] page;
    logic [15:0] sp;
  } ccsr_state_t;
endpackage : ccsr_pkg

// ### logic/ccsr_rf_if.sv
`timescale 1ns/1ps
interface ccsr_rf_if;
  import ccsr_pkg::*;
  logic [4:0] rd_a_idx;
  logic [4:0] rd_b_idx;
  logic [7:0] rd_a;
  logic [7:0] rd_b;
  logic [15:0] rd_w;
  logic [4:0] wr_idx;
  logic wr_en;
  logic wr_wide;
  logic [15:0] wr_data;
  modport core (output rd_a_idx, rd_b_idx, wr_idx, wr_en, wr_wide, wr_data,
    input rd_a, rd_b, rd_w);
  modport file (input rd_a_idx, rd_b_idx, wr_idx, wr_en, wr_wide, wr_data,
    output rd_a, rd_b, rd_w);
endinterface : ccsr_rf_if

// ### logic/ccsr_regfile.sv
`timescale 1ns/1ps
module ccsr_regfile (
  input wire logic clk_sys,
  input wire logic rst_n,
  ccsr_rf_if.file rf
);
  import ccsr_pkg::*;
  // ------------------------------------------------------------
  // 32 x 8 flops, two byte reads, one pair read, byte or pair write
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0][7:0] r;
  } ccsr_rf_state_t;
  ccsr_rf_state_t st;
  ccsr_rf_state_t next_st;
  logic [4:0] pair_hi;

  always_comb begin
    next_st = st;
    pair_hi = {rf.wr_idx[4:1], 1'b1};
    if (rf.wr_en) begin
      if (rf.wr_wide) begin
        next_st.r[{rf.wr_idx[4:1], 1'b0}] = rf.wr_data[7:0];
        next_st.r[pair_hi] = rf.wr_data[15:8];
      end else begin
        next_st.r[rf.wr_idx] = rf.wr_data[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // reads are combinational, but the core registers the operands, so an alu op takes two cycles
  assign rf.rd_a = st.r[rf.rd_a_idx];
  assign rf.rd_b = st.r[rf.rd_b_idx];
  assign rf.rd_w = {st.r[{rf.rd_a_idx[4:1], 1'b1}], st.r[{rf.rd_a_idx[4:1], 1'b0}]};
endmodule : ccsr_regfile

// ### testbench/ccsr_monitor.sv
`timescale 1ns/1ps
module ccsr_monitor (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire ccsr_pkg::ccsr_sp_op_t sp_op,
  input wire logic irq_enter,
  input wire logic irq_exit,
  input wire logic gate_set,
  input wire logic gate_clear,
  input wire logic irq_take,
  input wire logic [15:0] stack_ptr,
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic ext_table_access,
  input wire logic [15:0] z_prog_addr,
  input wire logic [16:0] prog_addr
);
  import ccsr_pkg::*;
  logic sp_free;
  // ------------------------------------------------------------
  // stack, gate, i/o and page checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // i/o writes to the stack pointer bytes and interrupt entry/exit take priority over plain stack ops
  assign sp_free = !io_wr && !irq_enter && !irq_exit;
  a_push_byte_step: assert property (sp_free && sp_op == SP_PUSH1 |=>
    stack_ptr == $past(stack_ptr) - 16'h0001) else $error("byte push step wrong");
  a_pop_byte_step: assert property (sp_free && sp_op == SP_POP1 |=>
    stack_ptr == $past(stack_ptr) + 16'h0001) else $error("byte pop step wrong");
  a_push_addr_step: assert property (sp_free && sp_op == SP_PUSH2 |=>
    stack_ptr == $past(stack_ptr) - 16'h0002) else $error("address push step wrong");
  a_irq_entry_sp: assert property (irq_enter && !irq_exit && !io_wr |=>
    stack_ptr == $past(stack_ptr) - 16'h0002) else $error("entry stack step wrong");
  a_irq_return_sp: assert property (irq_exit && !irq_enter && !io_wr |=>
    stack_ptr == $past(stack_ptr) + 16'h0002) else $error("return stack step wrong");
  a_gate_clear_block: assert property (gate_clear |=> !irq_take)
    else $error("interrupt taken in clear cycle");
  a_entry_gate_off: assert property (irq_enter ##1 !(gate_set || irq_exit) |=>
    !irq_take) else $error("interrupt taken after entry");
  a_sph_top_zero: assert property (io_rd && io_addr == IO_SP_HIGH |=>
    io_rdata[7:5] == 3'h0) else $error("stack high top bits not zero");
  a_page_top_zero: assert property (io_rd && io_addr == IO_PAGE_SELECT |=>
    io_rdata[7:1] == 7'h00) else $error("page top bits not zero");
  a_sign_xor: assert property (io_rd && io_addr == IO_STATUS |=>
    io_rdata[FLAG_S] == (io_rdata[FLAG_N] ^ io_rdata[FLAG_V])) else $error("sign flag wrong");
  a_lower_half: assert property (!ext_table_access |=>
    prog_addr == {1'b0, $past(z_prog_addr)}) else $error("plain load used page bit");
endmodule : ccsr_monitor

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import ccsr_pkg::*;
  logic clk_sys, rstn, alu_wr, alu_wide, bit_store, bit_load, irq_request, irq_enter;
  logic irq_exit, gate_set, gate_clear, irq_take, ds_wr, ds_rd, ds_hit, io_wr, io_rd;
  logic ext_table_access;
  logic [4:0] alu_src_a, alu_src_b, alu_dst;
  logic [2:0] bit_sel;
  logic [1:0] ptr_sel;
  logic [5:0] ptr_disp, io_addr;
  logic [7:0] alu_flags, alu_flag_mask, opnd_a, opnd_b, ds_wdata, ds_rdata, io_wdata;
  logic [7:0] io_rdata;
  logic [15:0] alu_result, opnd_w, stack_ptr, ptr_addr, ds_addr, z_prog_addr;
  logic [16:0] prog_addr;
  ccsr_sp_op_t sp_op;
  ccsr_ptr_mode_t ptr_mode;
  int n_fail, total_checks;
  // ------------------------------------------------------------
  // device, clock and access tasks
  // ------------------------------------------------------------
  ccsr_core_state DUT (.clk_sys, .rstn, .alu_src_a, .alu_src_b, .alu_dst, .alu_wr, .alu_wide,
    .alu_result, .alu_flags, .alu_flag_mask, .opnd_a, .opnd_b, .opnd_w, .bit_store, .bit_load,
    .bit_sel, .irq_request, .irq_enter, .irq_exit, .gate_set, .gate_clear, .irq_take, .sp_op,
    .stack_ptr, .ptr_mode, .ptr_sel, .ptr_disp, .ptr_addr, .ds_addr, .ds_wr, .ds_rd, .ds_wdata,
    .ds_rdata, .ds_hit, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .ext_table_access,
    .z_prog_addr, .prog_addr);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // every task starts and ends 1 ns after a rising edge, so requests are back to back
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic io_w(input logic [5:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    tick();
    io_wr = 1'b0;
  endtask : io_w
  task automatic io_r(input logic [5:0] a, input logic [7:0] exp);
    io_addr = a;
    io_rd = 1'b1;
    tick();
    io_rd = 1'b0;
    chk("io_rdata", exp, io_rdata);
  endtask : io_r
  task automatic ds_w(input logic [15:0] a, input logic [7:0] d);
    ds_addr = a;
    ds_wdata = d;
    ds_wr = 1'b1;
    tick();
    ds_wr = 1'b0;
  endtask : ds_w
  task automatic sp_do(input ccsr_sp_op_t op, input logic [15:0] exp);
    sp_op = op;
    tick();
    sp_op = SP_HOLD;
    chk("stack_ptr", exp, stack_ptr);
  endtask : sp_do
  task automatic flags(input logic [7:0] f, input logic [7:0] m, input logic [7:0] exp);
    alu_flags = f;
    alu_flag_mask = m;
    tick();
    alu_flag_mask = 8'h00;
    io_r(IO_STATUS, exp);
  endtask : flags
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask : pulse
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
  initial begin
    {rstn, alu_wr, alu_wide, bit_store, bit_load, irq_request, irq_enter, irq_exit} = '0;
    {gate_set, gate_clear, ds_wr, ds_rd, io_wr, io_rd, ext_table_access} = '0;
    {alu_src_a, alu_src_b, alu_dst, bit_sel, ptr_sel, ptr_disp, io_addr} = '0;
    {alu_flags, alu_flag_mask, ds_wdata, io_wdata, alu_result, ds_addr, z_prog_addr} = '0;
    sp_op = SP_HOLD;
    ptr_mode = PTR_NONE;
    n_fail = 0;
    total_checks = 0;
    repeat (16) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    repeat (2) tick();
    chk("stack_ptr", 16'h10FF, stack_ptr);
    io_r(IO_SP_LOW, 8'hFF);
    io_r(IO_SP_HIGH, 8'h10);
    io_r(IO_PAGE_SELECT, 8'h00);
    io_r(IO_STATUS, 8'h00);
    $display("reset values done");
    io_w(IO_SP_HIGH, 8'hFF);
    io_r(IO_SP_HIGH, 8'h1F);
    io_w(IO_PAGE_SELECT, 8'hFF);
    io_r(IO_PAGE_SELECT, 8'h01);
    io_r(6'h3C, 8'h00);
    io_w(IO_SP_HIGH, 8'h02);
    io_w(IO_SP_LOW, 8'h00);
    sp_do(SP_PUSH1, 16'h01FF);
    sp_do(SP_PUSH2, 16'h01FD);
    sp_do(SP_POP1, 16'h01FE);
    pulse(irq_exit);
    chk("stack_ptr", 16'h0200, stack_ptr);
    io_r(IO_STATUS, 8'h80);
    $display("stack done");
    flags(8'h04, 8'h3F, 8'h94);
    flags(8'h01, 8'h01, 8'h95);
    flags(8'h2A, 8'h28, 8'hAD);
    flags(8'h02, 8'h06, 8'hBB);
    $display("status flags done");
    irq_request = 1'b1;
    tick();
    chk("irq_take", 1'b1, irq_take);
    pulse(gate_clear);
    chk("irq_take", 1'b0, irq_take);
    tick();
    chk("irq_take", 1'b0, irq_take);
    pulse(gate_set);
    tick();
    chk("irq_take", 1'b1, irq_take);
    pulse(irq_enter);
    chk("stack_ptr", 16'h01FE, stack_ptr);
    tick();
    chk("irq_take", 1'b0, irq_take);
    irq_request = 1'b0;
    io_r(IO_STATUS, 8'h3B);
    $display("interrupt gate done");
    ds_w(16'h0005, 8'hA5);
    ds_addr = 16'h0005;
    pulse(ds_rd);
    chk("ds_rdata", 8'hA5, ds_rdata);
    chk("ds_hit", 1'b1, ds_hit);
    {alu_src_a, alu_src_b, alu_dst, alu_result} = {5'h05, 5'h07, 5'h07, 16'h003C};
    pulse(alu_wr);
    tick();
    chk("opnd_a", 8'hA5, opnd_a);
    chk("opnd_b", 8'h3C, opnd_b);
    pulse(bit_store);
    io_r(IO_STATUS, 8'h7B);
    ds_w(16'h001E, 8'hFF);
    ds_w(16'h001F, 8'h12);
    alu_src_a = 5'h1E;
    tick();
    chk("opnd_w", 16'h12FF, opnd_w);
    {ptr_sel, ptr_disp} = {2'h2, 6'h3F};
    ptr_mode = PTR_DISP;
    tick();
    chk("ptr_addr", 16'h133E, ptr_addr);
    ptr_mode = PTR_POSTINC;
    tick();
    ptr_mode = PTR_PREDEC;
    chk("ptr_addr", 16'h12FF, ptr_addr);
    tick();
    ptr_mode = PTR_NONE;
    chk("opnd_w", 16'h1300, opnd_w);
    chk("ptr_addr", 16'h12FF, ptr_addr);
    tick();
    chk("opnd_w", 16'h12FF, opnd_w);
    alu_src_a = 5'h07;
    pulse(bit_load);
    tick();
    chk("opnd_a", 8'h3D, opnd_a);
    {alu_src_a, alu_dst, alu_result, alu_wide} = {5'h02, 5'h02, 16'hBEEF, 1'b1};
    pulse(alu_wr);
    alu_wide = 1'b0;
    tick();
    chk("opnd_w", 16'hBEEF, opnd_w);
    $display("register file done");
    {ext_table_access, z_prog_addr} = {1'b1, 16'hABCD};
    tick();
    chk("prog_addr", 17'h1_ABCD, prog_addr);
    ext_table_access = 1'b0;
    tick();
    chk("prog_addr", 17'h0_ABCD, prog_addr);
    $display("page select done");
    stop_test();
  end
endmodule : tb_top
bind ccsr_core_state ccsr_monitor mon (.clk_sys, .rstn, .sp_op, .irq_enter, .irq_exit,
  .gate_set, .gate_clear, .irq_take, .stack_ptr, .io_addr, .io_wr, .io_rd, .io_rdata,
  .ext_table_access, .z_prog_addr, .prog_addr);
